// File: ssm_timing_consts.svh
/*
  Register address, reset value and decode constants for the
  synchronous static memory timing configuration block.
  Assumes inclusion by bare name from the design and the bench.
*/
`ifndef SSM_TIMING_CONSTS_SVH
`define SSM_TIMING_CONSTS_SVH

`define SSM_CFG_ADDR 32'h4800001C
`define SSM_CFG_RESET 32'h00000000
// bits 31 and 15 are reserved and read as zero
`define SSM_WR_MASK 32'h7FFF7FFF
`define SSM_TYPE_ROM 2'h0
`define SSM_TYPE_FLASH 2'h2
`define SSM_ROW_CODE_RSVD 3'h6
`define SSM_ROW_CODE_MAX 3'h7
`define SSM_ROW_LAT_MAX 4'h8
`define SSM_ROM_COL_A 3'h2
`define SSM_ROM_COL_B 3'h5
`define SSM_FLASH_COL_MIN 3'h2
`define SSM_FLASH_COL_MAX 3'h6
`define SSM_FLASH_ROW_LAT 4'h1
`define SSM_FALLBACK_LAT 4'h8

`endif

// File: ssm_timing_pkg.sv
/*
  Types of the synchronous static memory timing configuration block.
  Assumes nothing beyond the constants header.
*/
package ssm_timing_pkg;

  typedef struct packed {
    logic reserved_hi;
    logic latch_mode_pair23;
    logic [1:0] memory_type_pair23;
    logic [1:0] column_width_pair23;
    logic [1:0] row_width_pair23;
    logic [2:0] row_to_read_latency_pair23;
    logic [2:0] read_to_data_latency_pair23;
    logic [1:0] enable_pair23;
    logic reserved_lo;
    logic latch_mode_pair01;
    logic [1:0] memory_type_pair01;
    logic [1:0] column_width_pair01;
    logic [1:0] row_width_pair01;
    logic [2:0] row_to_read_latency_pair01;
    logic [2:0] read_to_data_latency_pair01;
    logic [1:0] enable_pair01;
  } sync_cfg_t;

  typedef enum logic [1:0] {PH_IDLE, PH_ROW, PH_COL} phase_t;

  typedef struct packed {
    sync_cfg_t cfg;
    logic [31:0] rdata;
    phase_t phase;
    logic [4:0] cnt;
    logic [4:0] col_cyc;
    logic act;
    logic rd;
    logic latch;
    logic err;
  } state_t;

endpackage : ssm_timing_pkg

// File: sync_static_mem_timing_cfg.sv
/*
  Configuration register and access sequencer for synchronous static
  memory on partition pair 0/1: holds the configuration word and times
  activate -> read -> data latch from the programmed latencies.
  Assumes START and HALF_FREQ come from logic on CLK, and that software
  keeps its own programming obligations (see notes below).
*/
// Functional notes
// - the read command follows the activate after the row latency.
// - mask rom row codes 000..101 give 1..6 cycles and 111 gives 8.
// - data are latched the column latency after the read command.
// - with half frequency set, each latency cycle is two clock periods.
// - mask rom column codes 010 and 101 give 3 and 6 cycles.
// - fast flash column codes 011, 100, 101 give 4, 5 and 6 cycles.
`timescale 1ns/100ps
`include "ssm_timing_consts.svh"

module sync_static_mem_timing_cfg
  import ssm_timing_pkg::*;
(
  input wire logic CLK,
  input wire logic SRST,
  input wire logic [31:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic HALF_FREQ,
  input wire logic START,
  output logic ACT_CMD,
  output logic READ_CMD,
  output logic DATA_LATCH,
  output logic BUSY,
  output logic CFG_ERROR,
  output sync_cfg_t CFG
);

  state_t cur;
  state_t next_state;

  function automatic logic [3:0] row_lat(input logic [1:0] t,
                                         input logic [2:0] c);
    logic [3:0] r;
    r = {1'b0, c} + 4'h1;
    if (t == `SSM_TYPE_FLASH) begin
      // row field is don't-care for fast flash
      r = `SSM_FLASH_ROW_LAT;
    end else if (c == `SSM_ROW_CODE_MAX) begin
      r = `SSM_ROW_LAT_MAX;
    end else if (c == `SSM_ROW_CODE_RSVD) begin
      r = `SSM_FALLBACK_LAT;
    end
    return r;
  endfunction : row_lat

  function automatic logic [3:0] col_lat(input logic [1:0] t,
                                         input logic [2:0] c);
    logic [3:0] r;
    r = `SSM_FALLBACK_LAT;
    if (t == `SSM_TYPE_ROM) begin
      if (c == `SSM_ROM_COL_A || c == `SSM_ROM_COL_B) begin
        r = {1'b0, c} + 4'h1;
      end
    end else if (c >= `SSM_FLASH_COL_MIN && c <= `SSM_FLASH_COL_MAX) begin
      r = {1'b0, c} + 4'h1;
    end
    return r;
  endfunction : col_lat

  function automatic logic cfg_err(input sync_cfg_t f);
    logic e;
    e = 1'b0;
    if (f.memory_type_pair01 == `SSM_TYPE_ROM) begin
      e = (f.row_to_read_latency_pair01 == `SSM_ROW_CODE_RSVD) ||
          !(f.read_to_data_latency_pair01 == `SSM_ROM_COL_A ||
            f.read_to_data_latency_pair01 == `SSM_ROM_COL_B);
    end else if (f.memory_type_pair01 == `SSM_TYPE_FLASH) begin
      e = f.read_to_data_latency_pair01 < `SSM_FLASH_COL_MIN ||
          f.read_to_data_latency_pair01 > `SSM_FLASH_COL_MAX;
    end else begin
      e = 1'b1;
    end
    return e;
  endfunction : cfg_err

  // latency in memory clocks -> CLK periods
  function automatic logic [4:0] scale(input logic [3:0] l,
                                       input logic half);
    return half ? {l, 1'b0} : {1'b0, l};
  endfunction : scale

  logic [4:0] row_cyc;
  logic [4:0] col_cyc;
  logic accept;
  logic cfg_hit;

  assign cfg_hit = (ADDR == `SSM_CFG_ADDR);
  assign row_cyc = scale(row_lat(cur.cfg.memory_type_pair01,
                         cur.cfg.row_to_read_latency_pair01), HALF_FREQ);
  assign col_cyc = scale(col_lat(cur.cfg.memory_type_pair01,
                         cur.cfg.read_to_data_latency_pair01), HALF_FREQ);
  // a misprogrammed pair is never started rather than run on a guess
  assign accept = (cur.phase == PH_IDLE) && START &&
                  (cur.cfg.enable_pair01 != 2'h0) && !cfg_err(cur.cfg);

  always_comb begin
    next_state = cur;
    next_state.act = 1'b0;
    next_state.rd = 1'b0;
    next_state.latch = 1'b0;
    next_state.rdata = 32'h00000000;
    next_state.err = cfg_err(cur.cfg);
    if (WR && cfg_hit) begin
      next_state.cfg = sync_cfg_t'(WDATA & `SSM_WR_MASK);
    end
    if (RD && cfg_hit) begin
      next_state.rdata = cur.cfg;
    end
    case (cur.phase)
      PH_IDLE: begin
        if (accept) begin
          next_state.act = 1'b1;
          next_state.cnt = row_cyc - 5'h01;
          // column timing is frozen at start so a write cannot skew it
          next_state.col_cyc = col_cyc;
          next_state.phase = PH_ROW;
        end
      end
      PH_ROW: begin
        if (cur.cnt == 5'h00) begin
          next_state.rd = 1'b1;
          next_state.cnt = cur.col_cyc - 5'h01;
          next_state.phase = PH_COL;
        end else begin
          next_state.cnt = cur.cnt - 5'h01;
        end
      end
      PH_COL: begin
        if (cur.cnt == 5'h00) begin
          next_state.latch = 1'b1;
          next_state.phase = PH_IDLE;
        end else begin
          next_state.cnt = cur.cnt - 5'h01;
        end
      end
      default: begin
        next_state.phase = PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      cur <= '0;
      cur.cfg <= sync_cfg_t'(`SSM_CFG_RESET);
      cur.phase <= PH_IDLE;
    end else begin
      cur <= next_state;
    end
  end

  assign RDATA = cur.rdata;
  assign ACT_CMD = cur.act;
  assign READ_CMD = cur.rd;
  assign DATA_LATCH = cur.latch;
  assign BUSY = (cur.phase != PH_IDLE);
  assign CFG_ERROR = cur.err;
  assign CFG = cur.cfg;

  // helper logic for the checks below
  logic [4:0] gap_act;
  logic [4:0] gap_rd;
  logic [4:0] exp_row;
  logic [4:0] exp_col;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      gap_act <= 5'h00;
      gap_rd <= 5'h00;
      exp_row <= 5'h00;
      exp_col <= 5'h00;
    end else begin
      gap_act <= ACT_CMD ? 5'h01 : gap_act + 5'h01;
      gap_rd <= READ_CMD ? 5'h01 : gap_rd + 5'h01;
      if (accept) begin
        exp_row <= row_cyc;
        exp_col <= col_cyc;
      end
    end
  end

  property p_row_gap;
    @(posedge CLK) disable iff (SRST)
      READ_CMD |-> (gap_act == exp_row);
  endproperty
  a_row_gap: assert property (p_row_gap)
    else $error("read command not at row latency after activate");

  property p_col_gap;
    @(posedge CLK) disable iff (SRST)
      DATA_LATCH |-> (gap_rd == exp_col);
  endproperty
  a_col_gap: assert property (p_col_gap)
    else $error("data latch not at column latency after read");

  property p_rom_row8;
    @(posedge CLK) disable iff (SRST)
      (accept && cur.cfg.memory_type_pair01 == `SSM_TYPE_ROM &&
       cur.cfg.row_to_read_latency_pair01 == 3'h7 && !HALF_FREQ)
      |-> ##1 ACT_CMD ##8 READ_CMD;
  endproperty
  a_rom_row8: assert property (p_rom_row8)
    else $error("rom row code 111 did not give 8 cycles");

  property p_rom_row1;
    @(posedge CLK) disable iff (SRST)
      (accept && cur.cfg.memory_type_pair01 == `SSM_TYPE_ROM &&
       cur.cfg.row_to_read_latency_pair01 == 3'h0 && !HALF_FREQ)
      |-> ##1 ACT_CMD ##1 READ_CMD;
  endproperty
  a_rom_row1: assert property (p_rom_row1)
    else $error("rom row code 000 did not give 1 cycle");

  property p_half_row;
    @(posedge CLK) disable iff (SRST)
      (accept && cur.cfg.memory_type_pair01 == `SSM_TYPE_ROM &&
       cur.cfg.row_to_read_latency_pair01 == 3'h0 && HALF_FREQ)
      |-> ##1 ACT_CMD ##1 !READ_CMD ##1 READ_CMD;
  endproperty
  a_half_row: assert property (p_half_row)
    else $error("half frequency did not double the row latency");

  property p_rom_col3;
    @(posedge CLK) disable iff (SRST)
      (accept && cur.cfg.memory_type_pair01 == `SSM_TYPE_ROM &&
       cur.cfg.row_to_read_latency_pair01 == 3'h0 &&
       cur.cfg.read_to_data_latency_pair01 == 3'h2 && !HALF_FREQ)
      |-> ##2 READ_CMD ##1 (!DATA_LATCH) [*2] ##1 DATA_LATCH;
  endproperty
  a_rom_col3: assert property (p_rom_col3)
    else $error("rom column code 010 did not give 3 cycles");

  property p_flash_col5;
    @(posedge CLK) disable iff (SRST)
      (accept && cur.cfg.memory_type_pair01 == `SSM_TYPE_FLASH &&
       cur.cfg.read_to_data_latency_pair01 == 3'h4 && !HALF_FREQ)
      |-> ##2 READ_CMD ##5 DATA_LATCH;
  endproperty
  a_flash_col5: assert property (p_flash_col5)
    else $error("flash column code 100 did not give 5 cycles");

  property p_reset_clear;
    @(posedge CLK) disable iff (SRST)
      $fell(SRST) |-> (cur.cfg[31:16] == 16'h0000 && !cur.cfg.reserved_lo);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("pair 2/3 or reserved bits not clear after reset");

  property p_busy_span;
    @(posedge CLK) disable iff (SRST)
      ACT_CMD |-> BUSY [*2];
  endproperty
  a_busy_span: assert property (p_busy_span)
    else $error("busy dropped during the row wait");

  property p_rom_row5;
    @(posedge CLK) disable iff (SRST)
      (accept && cur.cfg.memory_type_pair01 == `SSM_TYPE_ROM &&
       cur.cfg.row_to_read_latency_pair01 == 3'h4 && !HALF_FREQ)
      |-> ##1 ACT_CMD ##5 READ_CMD;
  endproperty
  a_rom_row5: assert property (p_rom_row5)
    else $error("rom row code 100 did not give 5 cycles");

  property p_half_col;
    @(posedge CLK) disable iff (SRST)
      (accept && cur.cfg.memory_type_pair01 == `SSM_TYPE_ROM &&
       cur.cfg.row_to_read_latency_pair01 == 3'h0 &&
       cur.cfg.read_to_data_latency_pair01 == 3'h2 && HALF_FREQ)
      |-> ##1 ACT_CMD ##2 READ_CMD ##6 DATA_LATCH;
  endproperty
  a_half_col: assert property (p_half_col)
    else $error("half frequency did not double the column latency");

  property p_rom_col6;
    @(posedge CLK) disable iff (SRST)
      (accept && cur.cfg.memory_type_pair01 == `SSM_TYPE_ROM &&
       cur.cfg.row_to_read_latency_pair01 == 3'h1 &&
       cur.cfg.read_to_data_latency_pair01 == 3'h5 && !HALF_FREQ)
      |-> ##1 ACT_CMD ##2 READ_CMD ##6 DATA_LATCH;
  endproperty
  a_rom_col6: assert property (p_rom_col6)
    else $error("rom column code 101 did not give 6 cycles");

  // the row field is not used for flash, whatever software left in it
  property p_flash_row1;
    @(posedge CLK) disable iff (SRST)
      (accept && cur.cfg.memory_type_pair01 == `SSM_TYPE_FLASH && !HALF_FREQ)
      |-> ##1 ACT_CMD ##1 READ_CMD;
  endproperty
  a_flash_row1: assert property (p_flash_row1)
    else $error("flash read command not one cycle after activate");

  property p_cfg_block;
    @(posedge CLK) disable iff (SRST)
      (cur.phase == PH_IDLE && START && cfg_err(cur.cfg)) |-> ##1 !ACT_CMD;
  endproperty
  a_cfg_block: assert property (p_cfg_block)
    else $error("sequence started on a reserved latency code");

endmodule : sync_static_mem_timing_cfg

// File: ssm_mem_model.sv
/*
  Behavioural far side: a synchronous mask rom or flash that measures
  the spacing of the controller's commands in clock cycles.
  Assumes the command pulses are registered on clk.
*/
`timescale 1ns/100ps
module ssm_mem_model (
  input wire logic clk,
  input wire logic act,
  input wire logic rd_cmd,
  input wire logic latch,
  output logic [31:0] row_gap,
  output logic [31:0] col_gap,
  output logic [15:0] n_act,
  output logic [15:0] n_lat
);
  logic [31:0] cyc = 32'h0;
  logic [31:0] t_act = 32'h0;
  logic [31:0] t_rd = 32'h0;
  logic [15:0] acts = 16'h0;
  logic [15:0] lats = 16'h0;
  assign n_act = acts;
  assign n_lat = lats;
  // spacing is kept as cycle differences, so the pulse phase cancels out
  always @(posedge clk) begin
    cyc <= cyc + 32'h1;
    if (act) begin
      t_act <= cyc;
      acts <= acts + 16'h1;
    end
    if (rd_cmd) begin
      t_rd <= cyc;
      row_gap <= cyc - t_act;
    end
    if (latch) begin
      col_gap <= cyc - t_rd;
      lats <= lats + 16'h1;
    end
  end
endmodule : ssm_mem_model

// File: tb.sv
/*
  Self-checking bench for the pair 0/1 timing configuration block.
  Assumes the memory model file is compiled first.
*/
`timescale 1ns/100ps
`include "ssm_timing_consts.svh"
module tb;
  logic CLK = 1'b0;
  logic SRST = 1'b1;
  logic [31:0] ADDR = 32'h0;
  logic [31:0] WDATA = 32'h0;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic HALF_FREQ = 1'b0;
  logic START = 1'b0;
  logic [31:0] RDATA;
  logic ACT_CMD, READ_CMD, DATA_LATCH, BUSY, CFG_ERROR;
  ssm_timing_pkg::sync_cfg_t CFG;
  logic [31:0] row_gap, col_gap, v;
  logic [15:0] n_act, n_lat, a0;
  int miscompares = 0;
  int checks_done = 0;
  always #5 CLK = ~CLK;
  sync_static_mem_timing_cfg u_sync_static_mem_timing_cfg (.CLK(CLK),
    .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .HALF_FREQ(HALF_FREQ), .START(START),
    .ACT_CMD(ACT_CMD), .READ_CMD(READ_CMD), .DATA_LATCH(DATA_LATCH),
    .BUSY(BUSY), .CFG_ERROR(CFG_ERROR), .CFG(CFG));
  ssm_mem_model u_ssm_mem_model (.clk(CLK), .act(ACT_CMD),
    .rd_cmd(READ_CMD), .latch(DATA_LATCH), .row_gap(row_gap),
    .col_gap(col_gap), .n_act(n_act), .n_lat(n_lat));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask : rd
  // word for pair 0/1, enabled: type, row code, column code
  function automatic logic [31:0] w01(logic [1:0] t, logic [2:0] r,
                                      logic [2:0] c);
    return {18'h0, t, 4'h0, r, c, 2'h1};
  endfunction : w01
  // start twice in a row: the second request falls while busy
  task automatic seq(input logic [31:0] w, input logic h,
                     input logic [31:0] er, input logic [31:0] ec);
    logic [15:0] l0;
    wr(`SSM_CFG_ADDR, w);
    l0 = n_lat;
    a0 = n_act;
    @(posedge CLK);
    HALF_FREQ <= h;
    START <= 1'b1;
    repeat (2) @(posedge CLK);
    START <= 1'b0;
    chk({31'h0, BUSY}, 32'h1);
    for (int i = 0; i < 100 && n_lat == l0; i++) @(posedge CLK);
    chk(row_gap, h ? 2 * er : er);
    chk(col_gap, h ? 2 * ec : ec);
    chk({16'h0, n_act - a0}, 32'h1);
    chk({31'h0, BUSY}, 32'h0);
  endtask : seq
  task automatic test_done;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done
  initial begin
    #100000;
    miscompares++;
    test_done();
  end
  initial begin
    repeat (5) @(posedge CLK);
    SRST <= 1'b0;
    rd(`SSM_CFG_ADDR, v);
    chk(v, 32'h0);
    chk({31'h0, CFG_ERROR}, 32'h1);
    wr(`SSM_CFG_ADDR, 32'hFFFFFFFF);
    rd(`SSM_CFG_ADDR, v);
    chk(v, 32'h7FFF7FFF);
    chk(CFG, 32'h7FFF7FFF);
    wr(32'h48000020, 32'h0);
    rd(`SSM_CFG_ADDR, v);
    chk(v, 32'h7FFF7FFF);
    rd(32'h48000020, v);
    chk(v, 32'h0);
    // a second reset in mid-run must clear a fully written word
    @(posedge CLK);
    SRST <= 1'b1;
    repeat (2) @(posedge CLK);
    SRST <= 1'b0;
    rd(`SSM_CFG_ADDR, v);
    chk(v, 32'h0);
    for (int r = 0; r < 8; r++)
      if (r != 6)
        seq(w01(2'h0, r[2:0], 3'h2), 1'b0, r == 7 ? 8 : r + 1, 3);
    seq(w01(2'h0, 3'h1, 3'h5), 1'b0, 2, 6);
    seq(w01(2'h0, 3'h2, 3'h5), 1'b1, 3, 6);
    seq(w01(2'h0, 3'h0, 3'h2), 1'b1, 1, 3);
    // flash row field held at 111 as software must, next larger col
    for (int c = 3; c < 6; c++)
      seq(w01(2'h2, 3'h7, c[2:0]), c == 5, 1, c + 1);
    wr(`SSM_CFG_ADDR, w01(2'h0, 3'h0, 3'h0));
    a0 = n_act;
    @(posedge CLK);
    START <= 1'b1;
    @(posedge CLK);
    START <= 1'b0;
    repeat (20) @(posedge CLK);
    chk({31'h0, CFG_ERROR}, 32'h1);
    chk({16'h0, n_act}, {16'h0, a0});
    test_done();
  end
endmodule : tb
